/* rtl/rclm_pkg.sv */
/*
 * rclm_pkg: constants and types of the residual current limit monitor.
 * Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package rclm_pkg;
    // value widths
    localparam int VAL_W     = 16;
    localparam int SCALE_FRAC = 8;   // scaling factor has 8 fraction bits
    localparam int PCT_W     = 7;

    // channel register block: byte stride and word indices within it
    localparam int CH_STRIDE = 'h80;
    localparam logic [4:0] W_CTRL  = 5'h00;   // byte 0x00
    localparam logic [4:0] W_BASE  = 5'h01;   // byte 0x04
    localparam logic [4:0] W_SCALE = 5'h02;   // byte 0x08
    localparam logic [4:0] W_MINT  = 5'h03;   // byte 0x0c
    localparam logic [4:0] W_FLAGS = 5'h04;   // byte 0x10
    localparam logic [4:0] W_ACT   = 5'h05;   // byte 0x14
    localparam logic [4:0] W_THR0  = 5'h08;   // byte 0x20..0x44
    localparam logic [4:0] W_OFS0  = 5'h14;   // byte 0x50..0x74
    // global registers
    localparam logic [11:0] A_IRQ_STAT = 12'h400;
    localparam logic [11:0] A_IRQ_MASK = 12'h404;

    // control register fields
    localparam int CTRL_MODE_LSB  = 0;    // 3 bits, one-hot mode
    localparam int CTRL_REF_LSB   = 4;    // 4 bits, reference source
    localparam int CTRL_NSTEP_LSB = 8;    // 4 bits, steps in use
    localparam int CTRL_PCT_LSB   = 16;   // 7 bits, warning percent
    // flag bits, also the per-channel layout of status and mask
    localparam int F_WARN  = 0;
    localparam int F_OVER  = 1;
    localparam int F_ALARM = 2;
    localparam int F_N     = 3;

    // reset values
    localparam logic [VAL_W-1:0] BASE_RST  = 16'h0000;
    localparam logic [VAL_W-1:0] SCALE_RST = 16'h0000;
    localparam logic [VAL_W-1:0] MINT_RST  = 16'h0000;
    localparam logic [PCT_W-1:0] PCT_RST   = 7'h64;  // 100 percent

    // exceedance time unit
    localparam int TICK_NS = 1_000_000;   // 1 ms
    localparam int CLK_NS  = 10;
    localparam int TICK_CYC = TICK_NS / CLK_NS;

    typedef enum logic [2:0] {
        MODE_STATIC = 3'b001,
        MODE_DYN    = 3'b010,
        MODE_STEP   = 3'b100
    } rclm_mode_e;

    typedef struct packed {
        logic [PCT_W-1:0] pct;
        logic [3:0]       nstep;
        logic [3:0]       refsel;
        rclm_mode_e       mode;
        logic [VAL_W-1:0] base_offset;
        logic [VAL_W-1:0] scale;
        logic [VAL_W-1:0] min_time;
    } rclm_cfg_s;

    typedef struct packed {
        logic alarm;
        logic over;
        logic warn;
    } rclm_flag_s;
endpackage : rclm_pkg

/* rtl/rclm_top.sv */
/*
 * rclm_top: residual current limit monitor with an AHB-Lite slave.
 * Holds per-channel limit arithmetic, level flags, exceedance
 * timers, the alarm latch, the interrupt words and the registers.
 * Current and reference samples arrive synchronous to clk_i; the
 * bus is a single-slave AHB-Lite segment, always zero wait states.
 * Software keeps step thresholds ascending; hsize is ignored and
 * only whole aligned words are expected.
 */
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
module rclm_top #(
    parameter int NCH         = 4,
    parameter int NREF        = 12,
    parameter int MAX_STEPS   = 10,
    parameter int TICK_CYCLES = rclm_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // ahb-lite slave
    input  wire logic                  hsel_i,
    input  wire logic [11:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    output logic      [31:0]           hrdata_o,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    // measurements from the front end
    input  wire logic [NCH-1:0][rclm_pkg::VAL_W-1:0]  cur_i,
    input  wire logic [NREF-1:0][rclm_pkg::VAL_W-1:0] ref_i,
    // per-channel indications and interrupt
    output rclm_pkg::rclm_flag_s [NCH-1:0] flag_o,
    output logic                       irq_o
);
    import rclm_pkg::*;

    localparam int SW = NCH * F_N;

    // channel and reference index fields are 3 and 4 bits wide
    initial begin
        if (NCH < 1 || NCH > 8 || NREF < 1 || NREF > 16 ||
            MAX_STEPS < 1 || MAX_STEPS > 12 || TICK_CYCLES < 1)
            $error("rclm_top: unsupported parameter values");
    end

    // saturate a wide sum to the value width
    // clip, not wrap, so a large product never looks small
    function automatic logic [VAL_W-1:0] sat(input logic [33:0] v);
        sat = (v > 34'(16'hFFFF)) ? 16'hFFFF : v[VAL_W-1:0];
    endfunction : sat

    // is a byte address inside a channel block, and which word
    // bit 10 marks the global words above the channel blocks
    function automatic logic ch_hit(input logic [11:0] a);
        ch_hit = !a[10] && (int'(a[9:7]) < NCH);
    endfunction : ch_hit

    // per-channel configuration and step tables
    rclm_cfg_s              cfg  [NCH];
    logic [VAL_W-1:0]       thr  [NCH][MAX_STEPS];
    logic [VAL_W-1:0]       ofs  [NCH][MAX_STEPS];
    // derived levels and exceedance counts
    logic [VAL_W-1:0]       lim  [NCH];
    logic [VAL_W-1:0]       wlim [NCH];
    logic [VAL_W-1:0]       cnt  [NCH];
    // interrupt words and the shared time base
    logic [SW-1:0]          irq_stat;
    logic [SW-1:0]          irq_mask;
    logic [SW-1:0]          ev;
    logic [NCH-1:0]         ack;
    logic                   tick;
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;

    // bus data-phase capture
    logic                   wr_pend;
    logic [11:0]            wr_addr;
    logic                   addr_ok;

    assign addr_ok = hsel_i && htrans_i[1] && hready_i;
    assign hreadyout_o = 1'b1;   // never stalls: all accesses one cycle
    assign hresp_o     = 1'b0;

    // active limit and warning level per channel
    always_comb begin
        logic [VAL_W-1:0] rv;
        logic [VAL_W-1:0] so;
        logic [33:0]      w;
        // defaults keep the temporaries from reading as latches
        rv = '0;
        so = '0;
        w  = '0;
        for (int c = 0; c < NCH; c++) begin
            // reference codes past the last input read as zero
            rv = (int'(cfg[c].refsel) < NREF) ?
                 ref_i[cfg[c].refsel] : '0;
            so = '0;
            for (int s = 0; s < MAX_STEPS; s++) begin
                // ascending order: the last one passed is the highest
                if (s < int'(cfg[c].nstep) && rv > thr[c][s])
                    so = ofs[c][s];
            end
            unique case (cfg[c].mode)
                MODE_DYN: begin
                    w = 34'((32'(rv) * 32'(cfg[c].scale)) >> SCALE_FRAC)
                        + 34'(cfg[c].base_offset);
                end
                MODE_STEP: begin
                    // so stays zero when no step is set or passed
                    w = 34'(cfg[c].base_offset) + 34'(so);
                end
                default: begin
                    w = 34'(cfg[c].base_offset);
                end
            endcase
            lim[c] = sat(w);
            // a percentage over 100 puts the level at or above the limit
            // level recomputed from the live limit every cycle
            w = 34'(32'(lim[c]) * 32'(cfg[c].pct) / 32'd100);
            wlim[c] = sat(w);
        end
    end

    // millisecond time base for exceedance counting
    // one tick for all channels: exceedance time is good to one
    // tick only, the price of a single prescaler
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (int'(tick_cnt) == TICK_CYCLES - 1) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick     <= 1'b0;
        end
    end

    // exceedance duration counters
    // counts saturate so a long exceedance never wraps to zero;
    // at or under the limit the count starts again from zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < NCH; c++) cnt[c] <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (cur_i[c] <= lim[c])
                    cnt[c] <= '0;
                else if (tick && cnt[c] != 16'hFFFF)
                    cnt[c] <= cnt[c] + 1'b1;
            end
        end
    end

    // indication flags; new alarm beats a same-cycle acknowledge
    // warning and overcurrent are levels one cycle behind the input;
    // the alarm is latched and only an acknowledge write drops it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < NCH; c++) flag_o[c] <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                flag_o[c].warn <= cur_i[c] > wlim[c];
                flag_o[c].over <= cur_i[c] > lim[c];
                if (cur_i[c] > lim[c] && tick &&
                    cnt[c] >= cfg[c].min_time)
                    flag_o[c].alarm <= 1'b1;
                else if (ack[c])
                    flag_o[c].alarm <= 1'b0;
            end
        end
    end

    // rising edges of the flags are the interrupt events
    // same terms as the flags, so status bit and flag rise on
    // the same edge
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ev[c*F_N+F_WARN]  = !flag_o[c].warn && cur_i[c] > wlim[c];
            ev[c*F_N+F_OVER]  = !flag_o[c].over && cur_i[c] > lim[c];
            ev[c*F_N+F_ALARM] = !flag_o[c].alarm && cur_i[c] > lim[c]
                                && tick && cnt[c] >= cfg[c].min_time;
        end
    end

    // acknowledge: write one to the alarm bit of a channel flags word
    // decoded in the data phase, so it acts on the edge that takes
    // the write data
    always_comb begin
        for (int c = 0; c < NCH; c++)
            ack[c] = wr_pend && ch_hit(wr_addr) &&
                     int'(wr_addr[9:7]) == c &&
                     wr_addr[6:2] == W_FLAGS && hwdata_i[F_ALARM];
    end

    // bus address phase capture
    // the address is kept for reads too; only wr_pend qualifies it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_ok && hwrite_i;
            wr_addr <= haddr_i;
        end
    end

    // configuration registers, written in the data phase
    // writes to unmapped words of a channel are dropped;
    // an illegal mode code is kept and then acts as static
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < NCH; c++) begin
                // every channel wakes up static with a zero limit
                cfg[c].pct         <= PCT_RST;
                cfg[c].nstep       <= '0;
                cfg[c].refsel      <= '0;
                cfg[c].mode        <= MODE_STATIC;
                cfg[c].base_offset <= BASE_RST;
                cfg[c].scale       <= SCALE_RST;
                cfg[c].min_time    <= MINT_RST;
                for (int s = 0; s < MAX_STEPS; s++) begin
                    thr[c][s] <= '0;
                    ofs[c][s] <= '0;
                end
            end
        end else if (wr_pend && ch_hit(wr_addr)) begin
            for (int c = 0; c < NCH; c++) begin
                if (int'(wr_addr[9:7]) == c) begin
                    if (wr_addr[6:2] == W_CTRL) begin
                        cfg[c].mode   <= rclm_mode_e'(
                            hwdata_i[CTRL_MODE_LSB +: 3]);
                        cfg[c].refsel <= hwdata_i[CTRL_REF_LSB +: 4];
                        cfg[c].nstep  <= hwdata_i[CTRL_NSTEP_LSB +: 4];
                        cfg[c].pct    <= hwdata_i[CTRL_PCT_LSB +: PCT_W];
                    end
                    if (wr_addr[6:2] == W_BASE)
                        cfg[c].base_offset <= hwdata_i[VAL_W-1:0];
                    if (wr_addr[6:2] == W_SCALE)
                        cfg[c].scale <= hwdata_i[VAL_W-1:0];
                    if (wr_addr[6:2] == W_MINT)
                        cfg[c].min_time <= hwdata_i[VAL_W-1:0];
                    // no order check: software keeps thresholds rising
                    for (int s = 0; s < MAX_STEPS; s++) begin
                        if (wr_addr[6:2] == W_THR0 + 5'(s))
                            thr[c][s] <= hwdata_i[VAL_W-1:0];
                        if (wr_addr[6:2] == W_OFS0 + 5'(s))
                            ofs[c][s] <= hwdata_i[VAL_W-1:0];
                    end
                end
            end
        end
    end

    // interrupt status (write one to clear, set wins) and mask
    // an event in the clearing cycle stays set so none is lost
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_pend && wr_addr == A_IRQ_STAT)
                irq_stat <= (irq_stat & ~hwdata_i[SW-1:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            if (wr_pend && wr_addr == A_IRQ_MASK)
                irq_mask <= hwdata_i[SW-1:0];
        end
    end

    // level output; software removes the cause via the status word
    assign irq_o = |(irq_stat & irq_mask);

    // read data, registered at the address phase
    // the bus never stalls, so a read right after a write to the
    // same word still sees the old value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= '0;
        end else if (addr_ok && !hwrite_i) begin
            hrdata_o <= '0;   // unmapped and reserved read as zero
            if (haddr_i == A_IRQ_STAT)
                hrdata_o[SW-1:0] <= irq_stat;
            else if (haddr_i == A_IRQ_MASK)
                hrdata_o[SW-1:0] <= irq_mask;
            else if (ch_hit(haddr_i)) begin
                for (int c = 0; c < NCH; c++) begin
                    if (int'(haddr_i[9:7]) == c) begin
                        unique case (haddr_i[6:2])
                            W_CTRL: begin
                                hrdata_o[CTRL_MODE_LSB +: 3] <=
                                    cfg[c].mode;
                                hrdata_o[CTRL_REF_LSB +: 4] <=
                                    cfg[c].refsel;
                                hrdata_o[CTRL_NSTEP_LSB +: 4] <=
                                    cfg[c].nstep;
                                hrdata_o[CTRL_PCT_LSB +: PCT_W] <=
                                    cfg[c].pct;
                            end
                            W_BASE:  hrdata_o[15:0] <= cfg[c].base_offset;
                            W_SCALE: hrdata_o[15:0] <= cfg[c].scale;
                            W_MINT:  hrdata_o[15:0] <= cfg[c].min_time;
                            W_FLAGS: hrdata_o[2:0]  <= flag_o[c];
                            W_ACT:   hrdata_o <= {wlim[c], lim[c]};
                            // threshold and offset words
                            default: begin
                                for (int s = 0; s < MAX_STEPS; s++) begin
                                    if (haddr_i[6:2] == W_THR0 + 5'(s))
                                        hrdata_o[15:0] <= thr[c][s];
                                    if (haddr_i[6:2] == W_OFS0 + 5'(s))
                                        hrdata_o[15:0] <= ofs[c][s];
                                end
                            end
                        endcase
                    end
                end
            end
        end
    end
endmodule : rclm_top

/* verification/rclm_front.sv */
/*
 * rclm_front: behavioural model of the measurement front end.
 * Assumes the bench asks for samples; each lands one clock later.
 */
`timescale 1ns/1ns
module rclm_front #(
    parameter int NCH  = 4,
    parameter int NREF = 12
) (
    // clock
    input  wire logic                                  clk_i,
    // requested samples
    input  wire logic [NCH-1:0][rclm_pkg::VAL_W-1:0]  cur_set_i,
    input  wire logic [NREF-1:0][rclm_pkg::VAL_W-1:0] ref_set_i,
    // converted samples
    output logic      [NCH-1:0][rclm_pkg::VAL_W-1:0]  cur_o,
    output logic      [NREF-1:0][rclm_pkg::VAL_W-1:0] ref_o
);
    import rclm_pkg::*;
    // one conversion cycle, so inputs never move on the sampling edge
    always_ff @(posedge clk_i) begin
        cur_o <= cur_set_i;
        ref_o <= ref_set_i;
    end
endmodule : rclm_front

/* verification/rclm_monitor.sv */
/*
 * rclm_monitor: port-level assertions of the limit monitor.
 * Assumes it is bound into rclm_top and sees only its ports.
 */
`timescale 1ns/1ns
module rclm_monitor #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic                                 clk_i,
    input wire logic                                 rst_i,
    // bus
    input wire logic                                 hsel_i,
    input wire logic [11:0]                          haddr_i,
    input wire logic [1:0]                           htrans_i,
    input wire logic                                 hwrite_i,
    input wire logic [31:0]                          hwdata_i,
    input wire logic                                 hready_i,
    input wire logic [31:0]                          hrdata_o,
    input wire logic                                 hreadyout_o,
    input wire logic                                 hresp_o,
    // measurements and flags
    input wire logic [NCH-1:0][rclm_pkg::VAL_W-1:0] cur_i,
    input wire rclm_pkg::rclm_flag_s [NCH-1:0]       flag_o
);
    import rclm_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // zero wait states and OKAY only
    a_bus_ready_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus slave stalled or answered an error");
    // read data stands until the next read address phase
    a_rdata_holds: assert property (
        !$past(hsel_i && htrans_i[1] && hready_i && !hwrite_i)
        |-> $stable(hrdata_o)) else $error("read data changed unasked");
    // channel space beyond the last channel reads as zero
    a_unmapped_zero: assert property (
        $past(hsel_i && htrans_i[1] && hready_i && !hwrite_i
              && haddr_i[11:7] >= NCH && haddr_i < 12'h400)
        |-> hrdata_o == 32'h0000_0000) else $error("unmapped read not zero");
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam logic [11:0] ACK = 12'(i * CH_STRIDE + 4 * W_FLAGS);
        // a zero current can never be above any level
        a_idle_quiet: assert property (
            cur_i[i] == 16'h0000 |=> !flag_o[i].over && !flag_o[i].warn)
            else $error("flag set with zero current");
        a_over_cause: assert property (
            $rose(flag_o[i].over) |-> $past(cur_i[i]) != 16'h0000)
            else $error("overcurrent without current");
        a_warn_cause: assert property (
            $rose(flag_o[i].warn) |-> $past(cur_i[i]) != 16'h0000)
            else $error("warning without current");
        a_alarm_over: assert property (
            $rose(flag_o[i].alarm) |-> flag_o[i].over)
            else $error("alarm raised while not over the limit");
        // the latch only drops two edges after an ack write
        a_alarm_acked: assert property (
            $fell(flag_o[i].alarm) |-> $past(hwdata_i[F_ALARM]) &&
            $past(hsel_i && htrans_i[1] && hwrite_i && haddr_i == ACK, 2))
            else $error("alarm dropped without acknowledge");
    end
endmodule : rclm_monitor

bind rclm_top rclm_monitor #(.NCH(NCH)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .cur_i(cur_i), .flag_o(flag_o)
);

/* verification/tb_top.sv */
/*
 * tb_top: self-checking bench of the residual current limit monitor.
 * Assumes the front-end model and the bound monitor compile first.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    import rclm_pkg::*;
    localparam int NCH = 2;
    localparam int NREF = 12;
    logic                        clk_i = 1'b0;
    logic                        rst_i = 1'b1;
    logic                        hsel = 1'b0;
    logic [11:0]                 haddr = 12'h000;
    logic [1:0]                  htrans = 2'b00;
    logic                        hwrite = 1'b0;
    logic [31:0]                 hwdata = 32'h0000_0000;
    logic [31:0]                 hrdata;
    logic                        hready;
    logic                        hresp;
    logic                        irq;
    logic [NCH-1:0][VAL_W-1:0]   cur_set = '0;
    logic [NREF-1:0][VAL_W-1:0]  ref_set = '0;
    logic [NCH-1:0][VAL_W-1:0]   cur;
    logic [NREF-1:0][VAL_W-1:0]  refv;
    rclm_flag_s [NCH-1:0]        flags;
    logic [31:0]                 expq[$];
    logic [31:0]                 got;
    logic [31:0]                 exp_v;
    logic [15:0]                 r;
    logic [15:0]                 lim;
    event                        got_ev;
    int                          seed = 99;
    int                          bad_count = 0;
    int                          compares = 0;
    int                          srcs[6] = '{0, 0, 5, 5, 11, 11};
    logic [15:0]                 st_cur[6] = '{240, 241, 300, 301, 300, 240};
    logic [31:0]                 st_flg[6] = '{0, 1, 1, 3, 1, 0};
    logic [15:0]                 ofs[3] = '{50, 10, 30};
    logic [15:0]                 sref[5] = '{50, 150, 200, 250, 350};
    logic [15:0]                 slim[5] = '{5, 55, 55, 15, 35};

    rclm_top #(.NCH(NCH), .NREF(NREF), .MAX_STEPS(10), .TICK_CYCLES(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .cur_i(cur), .ref_i(refv),
        .flag_o(flags), .irq_o(irq));
    rclm_front #(.NCH(NCH), .NREF(NREF)) u_front (
        .clk_i(clk_i), .cur_set_i(cur_set), .ref_set_i(ref_set),
        .cur_o(cur), .ref_o(refv));

    // 100 MHz clock
    initial forever #5 clk_i = ~clk_i;

    // compare each result against the oldest noted expectation
    always @(got_ev) begin
        exp_v = expq.pop_front();
        `CHK(got, exp_v)
    end

    function automatic logic [11:0] ra(input int ch, input logic [4:0] w);
        return 12'(ch * CH_STRIDE) + {5'b0_0000, w, 2'b00};
    endfunction : ra

    // expected activity word: warning level over limit
    function automatic logic [31:0] act(input logic [15:0] l, input int p);
        return {16'(32'(l) * p / 100), l};
    endfunction : act

    task automatic ob(input logic [31:0] e, input logic [31:0] g);
        expq.push_back(e);
        got = g;
        ->got_ev;
        #1;
    endtask : ob

    task automatic ap(input logic [11:0] a, input logic w);
        @(posedge clk_i);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
    endtask : ap

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ap(a, 1'b1);
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        #1; // let the written value settle before it is looked at
    endtask : wr

    // expectation is noted before the transfer starts
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        ap(a, 1'b0);
        do @(posedge clk_i); while (hready !== 1'b1);
        got = hrdata;
        ->got_ev;
        #1;
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask : settle

    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // cut a hang short; the whole run needs under two thousand cycles
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values and an unmapped word
        rd(ra(0, W_CTRL), 32'h0064_0001);
        rd(ra(1, W_ACT), 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
        rd(A_IRQ_MASK, 32'h0000_0000);
        // static limit 300, warning at 80 percent
        wr(ra(0, W_BASE), 32'h0000_012C);
        wr(ra(0, W_CTRL), 32'h0050_0001);
        rd(ra(0, W_ACT), act(16'h012C, 80));
        wr(ra(0, W_MINT), 32'h0000_0002);
        cur_set[1] <= 16'h0005;
        foreach (st_cur[k]) begin
            cur_set[0] <= st_cur[k];
            settle();
            ob(st_flg[k], 32'(flags[0]));
        end
        // two short excursions must not add up to an alarm
        repeat (2) begin
            cur_set[0] <= 16'h0200;
            repeat (6) @(posedge clk_i);
            cur_set[0] <= 16'h0000;
            settle();
        end
        ob(32'h0, 32'(flags[0]));
        cur_set[0] <= 16'h0200;
        repeat (18) @(posedge clk_i);
        ob(32'h7, 32'(flags[0]));
        cur_set[0] <= 16'h0000;
        settle();
        ob(32'h4, 32'(flags[0]));
        ob(32'h7, 32'(flags[1]));
        // events are sticky; mask one in, clear it, then acknowledge
        rd(A_IRQ_STAT, 32'h0000_003F);
        ob(32'h0, 32'(irq));
        wr(A_IRQ_MASK, 32'h0000_0004);
        ob(32'h1, 32'(irq));
        wr(A_IRQ_STAT, 32'h0000_0004);
        ob(32'h0, 32'(irq));
        wr(ra(0, W_FLAGS), 32'h0000_0004);
        settle();
        ob(32'h0, 32'(flags[0]));
        // dynamic limit ref * 2 + 20 from several sources, warning 50 pct
        wr(ra(0, W_SCALE), 32'h0000_0200);
        wr(ra(0, W_BASE), 32'h0000_0014);
        foreach (srcs[k]) begin
            r = 16'($random(seed)) & 16'h03FF;
            ref_set[srcs[k]] <= r;
            wr(ra(0, W_CTRL), 32'h0032_0002 | (32'(srcs[k]) << 4));
            settle();
            lim = r * 16'h0002 + 16'h0014;
            rd(ra(0, W_ACT), act(lim, 50));
        end
        // steps 100/200/300 with offsets 50/10/30 over base 5
        wr(ra(0, W_BASE), 32'h0000_0005);
        for (int s = 0; s < 3; s++) begin
            wr(ra(0, 5'(W_THR0 + s)), 32'(100 * (s + 1)));
            wr(ra(0, 5'(W_OFS0 + s)), 32'(ofs[s]));
        end
        wr(ra(0, W_CTRL), 32'h0064_0304);
        foreach (sref[k]) begin
            ref_set[0] <= sref[k];
            settle();
            rd(ra(0, W_ACT), act(slim[k], 100));
        end
        wr(ra(0, W_CTRL), 32'h0064_0004);
        rd(ra(0, W_ACT), act(16'h0005, 100));
        end_sim();
    end
endmodule : tb_top
